// File: logic/gpmc_pkg.sv
`default_nettype none
package gpmc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ     = 40;
    localparam int MS_US       = 1000;
    localparam int MS_CYC      = MS_US * CLK_MHZ;
    localparam int EXIT_HI_MS  = 1000;
    localparam int EXIT_HI_CYC = EXIT_HI_MS * MS_CYC;
    // force pin must settle through the far synchroniser first
    localparam logic [25:0] PRE_CYC = 26'h0000004;
    localparam int TW = 20;
    // ------------------------------------------------------------
    // command set
    // ------------------------------------------------------------
    localparam logic [7:0] STBY_ID   = 8'hA1;
    localparam logic [7:0] PM_ID     = 8'hE1;
    localparam logic [3:0] ACK_OK    = 4'h3;
    localparam logic [3:0] STBY_STOP = 4'h0;
    localparam logic [3:0] STBY_SLP  = 4'h1;
    localparam logic [3:0] ARG_FULL  = 4'h0;
    localparam logic [3:0] ARG_PBAK  = 4'h1;
    localparam logic [3:0] ARG_PSTB  = 4'h2;
    localparam logic [3:0] ARG_BAK   = 4'h4;
    localparam logic [3:0] ARG_ADPT  = 4'h9;
    // duration word: {run, sleep, retry run, retry sleep}
    localparam int T_RUN  = 3 * TW;
    localparam int T_SLP  = 2 * TW;
    localparam int T_RUN2 = 1 * TW;
    localparam int T_SLP2 = 0;
    localparam logic [TW-1:0] ADPT_RUN_MS = 20'h003E8;
    localparam logic [TW-1:0] ADPT_SLP_MS = 20'h02710;
    localparam int ADPT_MOVE_SH = 2;
    // power enables {osc, rf, bb, io}
    localparam logic [3:0] PW_ALL  = 4'hF;
    localparam logic [3:0] PW_OSC  = 4'h9;
    localparam logic [3:0] PW_IO   = 4'h1;
    localparam logic [3:0] PW_NONE = 4'h0;
    // ------------------------------------------------------------
    // host register map (word index) and fields
    // ------------------------------------------------------------
    localparam logic [2:0] R_CTRL = 3'h0;
    localparam logic [2:0] R_RUN  = 3'h1;
    localparam logic [2:0] R_SLP  = 3'h2;
    localparam logic [2:0] R_RUN2 = 3'h3;
    localparam logic [2:0] R_SLP2 = 3'h4;
    localparam logic [2:0] R_STAT = 3'h5;
    localparam int C_ARG  = 0;
    localparam int C_KIND = 4;
    localparam logic [1:0] K_STBY = 2'h0;
    localparam logic [1:0] K_PM   = 2'h1;
    localparam logic [1:0] K_BYTE = 2'h2;
    localparam logic [1:0] K_EXIT = 2'h3;

    typedef enum logic [3:0] {
        M_FULL = 4'h0, M_STOP = 4'h1, M_SLEEP = 4'h2, M_PRUN = 4'h3, M_PSLP = 4'h4,
        M_ARUN = 4'h5, M_ASLP = 4'h6, M_BAK = 4'h7, M_IDLE = 4'h8
    } gpmc_mode_t;

    function automatic logic [7:0] gpmc_sum(input logic [7:0] id, input logic [3:0] arg,
                                            input logic [4*TW-1:0] t);
        logic [7:0] s;
        s = id ^ {4'h0, arg};
        for (int i = 0; i < 10; i++) begin
            s = s ^ t[8*i +: 8];
        end
        return s;
    endfunction
endpackage
`default_nettype wire

// File: logic/gpmc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface gpmc_link_if;
    import gpmc_pkg::*;
    logic             rx_stb;
    logic             i2c_stb;
    logic             cmd_v;
    logic [7:0]       cmd_id;
    logic [3:0]       cmd_arg;
    logic [4*TW-1:0]  cmd_t;
    logic [7:0]       cmd_sum;
    logic             force_on;
    logic             ack_v;
    logic [7:0]       ack_id;
    logic [3:0]       ack_res;
    logic             dev_lp;
    logic             dev_woke;
    logic             dev_bak;

    modport dev (input rx_stb, i2c_stb, cmd_v, cmd_id, cmd_arg, cmd_t, cmd_sum, force_on,
                 output ack_v, ack_id, ack_res, dev_lp, dev_woke, dev_bak);
    modport host (output rx_stb, i2c_stb, cmd_v, cmd_id, cmd_arg, cmd_t, cmd_sum, force_on,
                  input ack_v, ack_id, ack_res, dev_lp, dev_woke, dev_bak);
endinterface
`default_nettype wire

// File: logic/gpmc_ms_timer.sv
`timescale 1ns/10ps
`default_nettype none
module gpmc_ms_timer
    import gpmc_pkg::*;
#(
    parameter int CYC_PER_MS = MS_CYC
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // control
    input  wire logic          load,
    input  wire logic [TW-1:0] load_ms,
    output logic               done
);
    localparam logic [25:0] CYC_M1 = 26'(CYC_PER_MS - 1);

    typedef struct packed {
        logic [25:0]   cyc;
        logic [TW-1:0] ms;
        logic          done;
    } gpmc_tmr_t;

    gpmc_tmr_t q, d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (load) begin
            // zero would never finish; treat as one millisecond
            d.ms  = (load_ms == '0) ? TW'(1) : load_ms;
            d.cyc = CYC_M1;
        end else if (q.ms != '0) begin
            if (q.cyc == '0) begin
                d.cyc  = CYC_M1;
                d.ms   = q.ms - TW'(1);
                d.done = (q.ms == TW'(1));
            end else begin
                d.cyc = q.cyc - 26'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign done = q.done;
endmodule // gpmc_ms_timer
`default_nettype wire

// File: logic/gpmc_dev.sv
`timescale 1ns/10ps
`default_nettype none
module gpmc_dev
    import gpmc_pkg::*;
#(
    parameter int CYC_PER_MS = MS_CYC
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    // supplies and navigation status
    input  wire logic        MAIN_PWR,
    input  wire logic        BAT_PWR,
    input  wire logic        FIX_OK,
    input  wire logic        MOTION,
    // power domain enables, hot start pulse and current mode
    output logic             OSC_ON,
    output logic             RF_ON,
    output logic             BB_ON,
    output logic             IO_ON,
    output logic             HOT_START,
    output var gpmc_mode_t   MODE,
    // link to host
    gpmc_link_if.dev         lnk
);
    typedef struct packed {
        logic [2:0]      s1;
        logic [2:0]      s2;
        gpmc_mode_t      st;
        logic            ptbak;
        logic [4*TW-1:0] tm;
        logic            woke;
        logic            fixed;
        logic            retry;
        logic            by_sup;
        logic            ack_v;
        logic            hot;
        logic [3:0]      pwr;
    } gpmc_dev_q_t;

    gpmc_dev_q_t     q, d;
    logic            t_ld;
    logic [TW-1:0]   t_ms;
    logic            t_done;
    logic            fon;
    logic            mpw;
    logic            bpw;
    logic            sum_ok;
    logic            std_ok;
    logic            pm_ok;
    logic            cmd_ok;
    logic            is_pm;
    logic            adp;

    gpmc_ms_timer #(
        .CYC_PER_MS (CYC_PER_MS)
    ) gpmc_ms_timer_inst (
        .clk     (CLK),
        .rst_n   (RST_N),
        .ce      (CE),
        .load    (t_ld),
        .load_ms (t_ms),
        .done    (t_done)
    );

    // ------------------------------------------------------------
    // command check
    // ------------------------------------------------------------
    assign fon    = q.s2[2];
    assign mpw    = q.s2[1];
    assign bpw    = q.s2[0];
    assign sum_ok = (lnk.cmd_sum == gpmc_sum(lnk.cmd_id, lnk.cmd_arg, lnk.cmd_t));
    assign std_ok = (lnk.cmd_id == STBY_ID) && (lnk.cmd_arg == STBY_STOP
                    || lnk.cmd_arg == STBY_SLP);
    assign pm_ok  = (lnk.cmd_id == PM_ID) && (lnk.cmd_arg == ARG_FULL
                    || lnk.cmd_arg == ARG_PBAK || lnk.cmd_arg == ARG_PSTB
                    || lnk.cmd_arg == ARG_BAK || lnk.cmd_arg == ARG_ADPT);
    assign cmd_ok = lnk.cmd_v && sum_ok && (std_ok || pm_ok);
    assign is_pm  = (lnk.cmd_id == PM_ID);
    assign adp    = (q.st == M_ARUN) || (q.st == M_ASLP);

    function automatic logic [3:0] pwr_of(input gpmc_mode_t st, input logic ptbak);
        case (st)
            M_STOP:  pwr_of = PW_IO;
            M_SLEEP: pwr_of = PW_OSC;
            M_PSLP:  pwr_of = ptbak ? PW_IO : PW_OSC;
            M_ASLP:  pwr_of = PW_OSC;
            M_IDLE:  pwr_of = PW_OSC;
            M_BAK:   pwr_of = PW_NONE;
            default: pwr_of = PW_ALL;
        endcase
    endfunction

    // ------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        t_ld = 1'b0;
        t_ms = '0;
        d.s1 = {lnk.force_on, MAIN_PWR, BAT_PWR};
        d.s2 = q.s1;
        d.ack_v = 1'b0;
        d.hot = 1'b0;
        case (q.st)
            M_FULL: begin
                if (cmd_ok && !is_pm) begin
                    d.st = (lnk.cmd_arg == STBY_STOP) ? M_STOP : M_SLEEP;
                end else if (cmd_ok) begin
                    d.ack_v = 1'b1;
                    case (lnk.cmd_arg)
                        ARG_PBAK, ARG_PSTB: begin
                            d.st    = M_PRUN;
                            d.ptbak = (lnk.cmd_arg == ARG_PBAK);
                            d.tm    = lnk.cmd_t;
                            d.woke  = 1'b0;
                            d.retry = 1'b0;
                            d.fixed = 1'b0;
                            t_ld    = 1'b1;
                            t_ms    = lnk.cmd_t[T_RUN +: TW];
                        end
                        ARG_ADPT: begin
                            d.st    = M_ARUN;
                            d.woke  = 1'b0;
                            d.retry = 1'b0;
                            d.fixed = 1'b0;
                            t_ld    = 1'b1;
                            t_ms    = ADPT_RUN_MS;
                        end
                        ARG_BAK: begin
                            d.st = fon ? M_IDLE : M_BAK;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            M_STOP, M_SLEEP, M_IDLE: begin
                // only the serial receive strobe counts, I2C is not looked at
                if (lnk.rx_stb) begin
                    d.st = M_FULL;
                end
            end
            M_PRUN, M_ARUN: begin
                d.fixed = q.fixed | FIX_OK;
                if (cmd_ok && is_pm && lnk.cmd_arg == ARG_FULL && q.woke) begin
                    d.st    = M_FULL;
                    d.ack_v = 1'b1;
                end else if (t_done && (q.fixed || q.retry)) begin
                    d.st = adp ? M_ASLP : M_PSLP;
                    t_ld = 1'b1;
                    if (adp) begin
                        t_ms = MOTION ? (ADPT_SLP_MS >> ADPT_MOVE_SH) : ADPT_SLP_MS;
                    end else begin
                        t_ms = q.retry ? q.tm[T_SLP2 +: TW] : q.tm[T_SLP +: TW];
                    end
                end else if (t_done) begin
                    d.retry = 1'b1;
                    t_ld    = 1'b1;
                    t_ms    = adp ? ADPT_RUN_MS : q.tm[T_RUN2 +: TW];
                end
            end
            M_PSLP, M_ASLP: begin
                if (t_done) begin
                    d.st    = adp ? M_ARUN : M_PRUN;
                    d.woke  = 1'b1;
                    d.retry = 1'b0;
                    d.fixed = 1'b0;
                    t_ld    = 1'b1;
                    t_ms    = adp ? ADPT_RUN_MS : q.tm[T_RUN +: TW];
                end
            end
            M_BAK: begin
                // command inputs are not decoded here at all
                if (mpw && (fon || q.by_sup)) begin
                    d.st     = M_FULL;
                    d.hot    = 1'b1;
                    d.by_sup = 1'b0;
                end
            end
            default: begin
                d.st = M_FULL;
            end
        endcase
        // supply loss overrides whatever the sequencer decided
        if (!mpw && bpw && q.st != M_BAK) begin
            d.st     = M_BAK;
            d.by_sup = 1'b1;
            d.ack_v  = 1'b0;
        end else if (!mpw && !bpw) begin
            d.st     = M_FULL;
            d.tm     = '0;
            d.ptbak  = 1'b0;
            d.by_sup = 1'b0;
            d.woke   = 1'b0;
            d.ack_v  = 1'b0;
            d.hot    = 1'b0;
        end
        d.pwr = pwr_of(d.st, d.ptbak);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '{st: M_FULL, pwr: PW_ALL, default: '0};
        end else if (CE) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign OSC_ON       = q.pwr[3];
    assign RF_ON        = q.pwr[2];
    assign BB_ON        = q.pwr[1];
    assign IO_ON        = q.pwr[0];
    assign HOT_START    = q.hot;
    assign MODE         = q.st;
    assign lnk.ack_v    = q.ack_v;
    assign lnk.ack_id   = PM_ID;
    assign lnk.ack_res  = ACK_OK;
    assign lnk.dev_lp   = (q.st >= M_PRUN) && (q.st <= M_ASLP);
    assign lnk.dev_woke = q.woke && (q.st == M_PRUN || q.st == M_ARUN);
    assign lnk.dev_bak  = (q.st == M_BAK);
endmodule // gpmc_dev
`default_nettype wire

// File: logic/gpmc_host.sv
`timescale 1ns/10ps
`default_nettype none
module gpmc_host
    import gpmc_pkg::*;
#(
    parameter int EXIT_CYC = EXIT_HI_CYC
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    // register port
    input  wire logic [2:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // link to device
    gpmc_link_if.host        lnk
);
    localparam logic [25:0] EXIT_M1 = 26'(EXIT_CYC - 1);

    typedef enum logic [2:0] {
        H_IDLE = 3'h0, H_PRE = 3'h1, H_WAIT = 3'h2, H_SEND = 3'h3, H_EXIT = 3'h4
    } gpmc_hst_t;

    typedef struct packed {
        gpmc_hst_t       st;
        logic [1:0]      kind;
        logic [3:0]      arg;
        logic [4*TW-1:0] tm;
        logic            fon;
        logic [25:0]     cnt;
        logic            ack_seen;
        logic [3:0]      ack_res;
        logic [31:0]     rdata;
        logic            cmd_v;
        logic            rx_stb;
        logic [7:0]      cmd_id;
        logic [3:0]      cmd_arg;
        logic [4*TW-1:0] cmd_t;
        logic [7:0]      cmd_sum;
    } gpmc_host_q_t;

    gpmc_host_q_t q, d;
    logic [7:0]   id;

    assign id = (q.kind == K_STBY) ? STBY_ID : PM_ID;

    always_comb begin
        d = q;
        d.cmd_v = 1'b0;
        d.rx_stb = 1'b0;
        d.rdata = '0;
        // ------------------------------------------------------------
        // register port
        // ------------------------------------------------------------
        if (RD) begin
            case (ADDR)
                R_CTRL:  d.rdata = 32'({q.kind, q.arg});
                R_RUN:   d.rdata = 32'(q.tm[T_RUN +: TW]);
                R_SLP:   d.rdata = 32'(q.tm[T_SLP +: TW]);
                R_RUN2:  d.rdata = 32'(q.tm[T_RUN2 +: TW]);
                R_SLP2:  d.rdata = 32'(q.tm[T_SLP2 +: TW]);
                R_STAT:  d.rdata = 32'({q.fon, q.st != H_IDLE, lnk.dev_bak, lnk.dev_lp,
                                       lnk.dev_woke, q.ack_seen, q.ack_res});
                default: d.rdata = '0;
            endcase
            if (ADDR == R_STAT) begin
                d.ack_seen = 1'b0;
            end
        end
        // a new acknowledge beats the read clear
        if (lnk.ack_v) begin
            d.ack_seen = 1'b1;
            d.ack_res  = lnk.ack_res;
        end
        if (WR) begin
            case (ADDR)
                R_RUN:   d.tm[T_RUN +: TW]  = WDATA[TW-1:0];
                R_SLP:   d.tm[T_SLP +: TW]  = WDATA[TW-1:0];
                R_RUN2:  d.tm[T_RUN2 +: TW] = WDATA[TW-1:0];
                R_SLP2:  d.tm[T_SLP2 +: TW] = WDATA[TW-1:0];
                default: begin
                end
            endcase
        end
        // ------------------------------------------------------------
        // command sequencer
        // ------------------------------------------------------------
        case (q.st)
            H_IDLE: begin
                if (WR && ADDR == R_CTRL) begin
                    d.kind = WDATA[C_KIND +: 2];
                    d.arg  = WDATA[C_ARG +: 4];
                    d.st   = H_SEND;
                    if (WDATA[C_KIND +: 2] == K_BYTE) begin
                        d.rx_stb = 1'b1;
                        d.st     = H_IDLE;
                    end else if (WDATA[C_KIND +: 2] == K_EXIT) begin
                        d.fon = 1'b1;
                        d.cnt = EXIT_M1;
                        d.st  = H_EXIT;
                    end else if (WDATA[C_KIND +: 2] == K_PM && WDATA[C_ARG +: 4] == ARG_BAK) begin
                        d.fon = 1'b0;
                        d.cnt = PRE_CYC;
                        d.st  = H_PRE;
                    end else if (WDATA[C_KIND +: 2] == K_PM && WDATA[C_ARG +: 4] == ARG_FULL) begin
                        d.st = H_WAIT;
                    end
                end
            end
            H_PRE: begin
                if (q.cnt == '0) begin
                    d.st = H_SEND;
                end else begin
                    d.cnt = q.cnt - 26'h1;
                end
            end
            H_WAIT: begin
                if (lnk.dev_woke || !lnk.dev_lp) begin
                    d.st = H_SEND;
                end
            end
            H_SEND: begin
                d.cmd_v   = 1'b1;
                d.cmd_id  = id;
                d.cmd_arg = q.arg;
                d.cmd_t   = q.tm;
                d.cmd_sum = gpmc_sum(id, q.arg, q.tm);
                d.st      = H_IDLE;
            end
            H_EXIT: begin
                if (q.cnt == '0) begin
                    d.fon = 1'b0;
                    d.st  = H_IDLE;
                end else begin
                    d.cnt = q.cnt - 26'h1;
                end
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
        // quiet all outgoing lines but force_on while the device sleeps in backup
        if (lnk.dev_bak) begin
            d.cmd_v   = 1'b0;
            d.rx_stb  = 1'b0;
            d.cmd_id  = '0;
            d.cmd_arg = '0;
            d.cmd_t   = '0;
            d.cmd_sum = '0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '{st: H_IDLE, default: '0};
        end else if (CE) begin
            q <= d;
        end
    end

    assign RDATA        = q.rdata;
    assign lnk.cmd_v    = q.cmd_v;
    assign lnk.rx_stb   = q.rx_stb;
    assign lnk.i2c_stb  = 1'b0;
    assign lnk.cmd_id   = q.cmd_id;
    assign lnk.cmd_arg  = q.cmd_arg;
    assign lnk.cmd_t    = q.cmd_t;
    assign lnk.cmd_sum  = q.cmd_sum;
    assign lnk.force_on = q.fon;
endmodule // gpmc_host
`default_nettype wire

// File: sim/gpmc_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module gpmc_chk
    import gpmc_pkg::*;
(
    // clock and reset
    input wire logic            CLK,
    input wire logic            RST_N,
    // link signals
    input wire logic            cmd_v,
    input wire logic [7:0]      cmd_id,
    input wire logic [3:0]      cmd_arg,
    input wire logic [4*TW-1:0] cmd_t,
    input wire logic [7:0]      cmd_sum,
    input wire logic            force_on,
    input wire logic            ack_v,
    input wire logic [7:0]      ack_id,
    input wire logic [3:0]      ack_res,
    input wire logic            dev_lp,
    input wire logic            dev_woke,
    input wire logic            dev_bak
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // well-formed power-mode command seen on the link
    wire pm = cmd_v && cmd_id == PM_ID && cmd_sum == gpmc_sum(cmd_id, cmd_arg, cmd_t);

    property p_ack; ack_v |-> ack_id == PM_ID && ack_res == ACK_OK; endproperty
    a_ack: assert property (p_ack) else $error("ack fields wrong");
    property p_bad; pm && cmd_arg == 4'h3 |=> !ack_v; endproperty
    a_bad: assert property (p_bad) else $error("illegal arg acked");
    property p_per; pm && cmd_arg == ARG_PSTB && !dev_lp |=> dev_lp && ack_v; endproperty
    a_per: assert property (p_per) else $error("periodic not entered");
    property p_adp; pm && cmd_arg == ARG_ADPT && !dev_lp |=> dev_lp && ack_v; endproperty
    a_adp: assert property (p_adp) else $error("adaptive not entered");
    property p_ext; pm && cmd_arg == ARG_FULL && dev_woke |=> !dev_lp && ack_v; endproperty
    a_ext: assert property (p_ext) else $error("no exit after wake");
    property p_bin; !force_on [*4] ##0 (pm && cmd_arg == ARG_BAK) |=> dev_bak; endproperty
    a_bin: assert property (p_bin) else $error("backup not entered");
    property p_bhd; dev_bak && !force_on |=> dev_bak; endproperty
    a_bhd: assert property (p_bhd) else $error("backup left early");
    property p_bex; dev_bak && $rose(force_on) |-> ##[1:4] !dev_bak; endproperty
    a_bex: assert property (p_bex) else $error("force pin no exit");
endmodule // gpmc_chk
`default_nettype wire

// File: sim/gpmc_tb.sv
`timescale 1ns/10ps
`default_nettype none
module gpmc_tb
    import gpmc_pkg::*;
;
    logic        clk, rst_n, main_pwr, fix_ok, motion, wr, rd, hot, hot_seen;
    logic        osc_on, rf_on, bb_on, io_on;
    logic [2:0]  addr;
    logic [31:0] wdata, rdata, d;
    gpmc_mode_t  mode;
    int          bad_count, compares;

    gpmc_link_if lnk ();
    gpmc_dev #(.CYC_PER_MS(4)) gpmc_dev_inst (.CLK(clk), .RST_N(rst_n), .CE(1'b1),
        .MAIN_PWR(main_pwr), .BAT_PWR(1'b1), .FIX_OK(fix_ok), .MOTION(motion),
        .OSC_ON(osc_on), .RF_ON(rf_on), .BB_ON(bb_on), .IO_ON(io_on),
        .HOT_START(hot), .MODE(mode), .lnk(lnk.dev));
    gpmc_host #(.EXIT_CYC(20)) gpmc_host_inst (.CLK(clk), .RST_N(rst_n), .CE(1'b1),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .lnk(lnk.host));
    gpmc_chk gpmc_chk_inst (.CLK(clk), .RST_N(rst_n), .cmd_v(lnk.cmd_v),
        .cmd_id(lnk.cmd_id), .cmd_arg(lnk.cmd_arg), .cmd_t(lnk.cmd_t),
        .cmd_sum(lnk.cmd_sum), .force_on(lnk.force_on), .ack_v(lnk.ack_v),
        .ack_id(lnk.ack_id), .ack_res(lnk.ack_res), .dev_lp(lnk.dev_lp),
        .dev_woke(lnk.dev_woke), .dev_bak(lnk.dev_bak));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
    // bounded wait; also catches the one-cycle hot start pulse
    task automatic wait_mode(input gpmc_mode_t m, input int n);
        for (int i = 0; i < n && mode !== m; i++) begin
            @(posedge clk);
            #1 hot_seen |= hot;
        end
        chk(32'(mode), 32'(m));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_stby;
        for (int k = 0; k < 2; k++) begin
            wreg(R_CTRL, {26'h0, K_STBY, 4'(k)});
            wait_mode(k ? M_SLEEP : M_STOP, 10);
            chk({osc_on, rf_on, bb_on, io_on}, {k[0], 3'h1});
            wreg(R_CTRL, {26'h0, K_BYTE, 4'h0});
            wait_mode(M_FULL, 10);
        end
    endtask
    task automatic t_per;
        // no fix here, so the first run has to be retried before any sleep
        for (int r = 1; r < 5; r++) wreg(3'(r), 32'h1);
        wreg(R_CTRL, {26'h0, K_PM, ARG_PSTB});
        wait_mode(M_PRUN, 10);
        rreg(R_STAT);
        chk(d[4:0], 5'h13);
        repeat (4) @(posedge clk);
        #1 chk(32'(mode), 32'(M_PRUN));
        wait_mode(M_PSLP, 40);
        chk({osc_on, rf_on}, 2'h2);
        wreg(R_CTRL, {26'h0, K_PM, ARG_FULL});
        wait_mode(M_FULL, 60);
    endtask
    task automatic t_bad;
        rreg(R_STAT);
        wreg(R_CTRL, {26'h0, K_PM, 4'h3});
        wreg(R_CTRL, {26'h0, K_STBY, 4'h2});
        repeat (4) @(posedge clk);
        rreg(R_STAT);
        chk(d[4], 1'b0);
        chk(32'(mode), 32'(M_FULL));
    endtask
    task automatic t_bak;
        wreg(R_CTRL, {26'h0, K_PM, ARG_BAK});
        wait_mode(M_BAK, 20);
        chk(io_on, 1'b0);
        wreg(R_CTRL, {26'h0, K_BYTE, 4'h0});
        #1 chk(lnk.rx_stb, 1'b0);
        wreg(R_CTRL, {26'h0, K_STBY, STBY_SLP});
        repeat (5) @(posedge clk);
        chk(32'(mode), 32'(M_BAK));
        hot_seen = 1'b0;
        wreg(R_CTRL, {26'h0, K_EXIT, 4'h0});
        wait_mode(M_FULL, 10);
        chk(hot_seen, 1'b1);
        repeat (25) @(posedge clk);
    endtask
    task automatic t_adpt;
        motion <= 1'b1;
        fix_ok <= 1'b1;
        wreg(R_CTRL, {26'h0, K_PM, ARG_ADPT});
        wait_mode(M_ARUN, 10);
        wreg(R_CTRL, {26'h0, K_PM, ARG_FULL});
        wait_mode(M_FULL, 20000);
    endtask
    task automatic finish_test;
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst_n, fix_ok, motion, wr, rd, hot_seen, addr, wdata} = '0;
        main_pwr  = 1'b1;
        bad_count = 0;
        compares  = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_stby;
        t_per;
        t_bad;
        t_bak;
        t_adpt;
        finish_test;
    end
    // run needs about 14000 cycles
    initial begin
        #(25 * 60000);
        bad_count++;
        finish_test;
    end
endmodule // gpmc_tb
`default_nettype wire
